// File: rtl/csf_pkg.sv
// constants, operation codes and cycle counts for the status flag and flow block
package csf_pkg;

    localparam logic [5:0] CSF_STATUS_ADDR = 6'h3f;
    localparam logic [7:0] CSF_STATUS_RESET = 8'h00;

    localparam int CSF_BIT_I = 7;
    localparam int CSF_BIT_T = 6;
    localparam int CSF_BIT_H = 5;
    localparam int CSF_BIT_S = 4;
    localparam int CSF_BIT_V = 3;
    localparam int CSF_BIT_N = 2;
    localparam int CSF_BIT_Z = 1;
    localparam int CSF_BIT_C = 0;

    localparam logic [2:0] CSF_CYC_ONE = 3'h1;
    localparam logic [2:0] CSF_CYC_JUMP = 3'h2;
    localparam logic [2:0] CSF_CYC_CALL = 3'h3;
    localparam logic [2:0] CSF_CYC_RET = 3'h4;
    localparam logic [2:0] CSF_CYC_BRANCH = 3'h2;
    localparam logic [2:0] CSF_CYC_IRQ = 3'h4;
    localparam logic [2:0] CSF_CYC_SKIP_ONE = 3'h2;
    localparam logic [2:0] CSF_CYC_SKIP_TWO = 3'h3;

    typedef enum logic [5:0] {
        CSF_NOP = 6'h00,
        CSF_ADD = 6'h01,
        CSF_ADC = 6'h02,
        CSF_SUB = 6'h03,
        CSF_SBC = 6'h04,
        CSF_CP = 6'h05,
        CSF_CPC = 6'h06,
        CSF_AND = 6'h07,
        CSF_OR = 6'h08,
        CSF_EOR = 6'h09,
        CSF_COM = 6'h0a,
        CSF_NEG = 6'h0b,
        CSF_INC = 6'h0c,
        CSF_DEC = 6'h0d,
        CSF_SER = 6'h0e,
        CSF_ADIW = 6'h0f,
        CSF_SBIW = 6'h10,
        CSF_TBIT_STORE = 6'h11,
        CSF_TBIT_LOAD = 6'h12,
        CSF_RJMP = 6'h13,
        CSF_IJMP = 6'h14,
        CSF_JMP = 6'h15,
        CSF_RCALL = 6'h16,
        CSF_ICALL = 6'h17,
        CSF_CALL = 6'h18,
        CSF_RET = 6'h19,
        CSF_IRQ_RET = 6'h1a,
        CSF_CPSE = 6'h1b,
        CSF_SBRC = 6'h1c,
        CSF_SBRS = 6'h1d,
        CSF_SBIC = 6'h1e,
        CSF_SBIS = 6'h1f,
        CSF_BRBS = 6'h20,
        CSF_BRBC = 6'h21
    } csf_op_t;

endpackage

// File: rtl/csf_flag_unit.sv
// combinational result and flag computation for byte, word and bit operations
`timescale 1ns/1ps
module csf_flag_unit
    import csf_pkg::*;
(
    input wire csf_op_t op,
    input wire logic [7:0] a,
    input wire logic [7:0] a_hi,
    input wire logic [7:0] b,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] flags_in,
    output logic [15:0] res,
    output logic [7:0] flags_out,
    output logic wb
);
    logic is_add;
    logic use_c;
    logic [7:0] sa;
    logic [7:0] sb;
    logic [8:0] sum;
    logic [7:0] r;
    logic [16:0] wsum;
    logic h_add;
    logic h_sub;
    logic v_add;
    logic v_sub;

    assign is_add = (op == CSF_ADD) || (op == CSF_ADC);
    assign use_c = (op == CSF_ADC) || (op == CSF_SBC) || (op == CSF_CPC);
    assign sa = (op == CSF_NEG) ? 8'h00 : a;
    assign sb = (op == CSF_NEG) ? a : b;
    assign sum = is_add ? ({1'b0, sa} + {1'b0, sb} + {8'h00, use_c & flags_in[CSF_BIT_C]})
                        : ({1'b0, sa} - {1'b0, sb} - {8'h00, use_c & flags_in[CSF_BIT_C]});
    assign r = sum[7:0];
    // half carry out of / borrow into bit 3
    assign h_add = (sa[3] & sb[3]) | (sb[3] & ~r[3]) | (~r[3] & sa[3]);
    assign h_sub = (~sa[3] & sb[3]) | (sb[3] & r[3]) | (r[3] & ~sa[3]);
    assign v_add = (sa[7] & sb[7] & ~r[7]) | (~sa[7] & ~sb[7] & r[7]);
    assign v_sub = (sa[7] & ~sb[7] & ~r[7]) | (~sa[7] & sb[7] & r[7]);
    assign wsum = (op == CSF_SBIW) ? ({1'b0, a_hi, a} - {9'h000, b})
                                   : ({1'b0, a_hi, a} + {9'h000, b});

    always_comb begin
        res = 16'h0000;
        flags_out = flags_in;
        wb = 1'b0;
        case (op)
            // byte arithmetic and compares
            CSF_ADD, CSF_ADC, CSF_SUB, CSF_SBC, CSF_CP, CSF_CPC, CSF_NEG: begin
                res = {8'h00, r};
                // compares write nothing back
                wb = (op != CSF_CP) && (op != CSF_CPC);
                // result flags
                flags_out[CSF_BIT_Z] = (r == 8'h00);
                flags_out[CSF_BIT_N] = r[7];
                flags_out[CSF_BIT_C] = sum[8];
                flags_out[CSF_BIT_H] = is_add ? h_add : h_sub;
                flags_out[CSF_BIT_V] = is_add ? v_add : v_sub;
            end
            // logic group leaves carry and half carry
            CSF_AND, CSF_OR, CSF_EOR, CSF_INC, CSF_DEC: begin
                case (op)
                    CSF_AND: res = {8'h00, a & b};
                    CSF_OR: res = {8'h00, a | b};
                    CSF_EOR: res = {8'h00, a ^ b};
                    CSF_INC: res = {8'h00, a + 8'h01};
                    default: res = {8'h00, a - 8'h01};
                endcase
                wb = 1'b1;
                flags_out[CSF_BIT_Z] = (res[7:0] == 8'h00);
                flags_out[CSF_BIT_N] = res[7];
                flags_out[CSF_BIT_V] = (op == CSF_INC) ? (res[7:0] == 8'h80) :
                                       (op == CSF_DEC) ? (res[7:0] == 8'h7f) : 1'b0;
            end
            // one's complement as ff minus operand
            CSF_COM: begin
                res = {8'h00, 8'hff - a};
                wb = 1'b1;
                flags_out[CSF_BIT_Z] = (res[7:0] == 8'h00);
                flags_out[CSF_BIT_N] = res[7];
                flags_out[CSF_BIT_C] = 1'b1;
                flags_out[CSF_BIT_V] = 1'b0;
            end
            // all ones, flags untouched
            CSF_SER: begin
                res = 16'h00ff;
                wb = 1'b1;
            end
            // sixteen-bit pair arithmetic
            CSF_ADIW, CSF_SBIW: begin
                res = wsum[15:0];
                wb = 1'b1;
                flags_out[CSF_BIT_Z] = (wsum[15:0] == 16'h0000);
                flags_out[CSF_BIT_N] = wsum[15];
                if (op == CSF_ADIW) begin
                    flags_out[CSF_BIT_V] = ~a_hi[7] & wsum[15];
                    flags_out[CSF_BIT_C] = a_hi[7] & ~wsum[15];
                end else begin
                    flags_out[CSF_BIT_V] = a_hi[7] & ~wsum[15];
                    flags_out[CSF_BIT_C] = wsum[15] & ~a_hi[7];
                end
            end
            // bit copy in both directions
            CSF_TBIT_STORE: flags_out[CSF_BIT_T] = a[bit_sel];
            CSF_TBIT_LOAD: begin
                res = {8'h00, a};
                res[bit_sel] = flags_in[CSF_BIT_T];
                wb = 1'b1;
            end
            default: begin
                res = 16'h0000;
            end
        endcase
        // sign kept as negative xor overflow
        flags_out[CSF_BIT_S] = flags_out[CSF_BIT_N] ^ flags_out[CSF_BIT_V];
    end

endmodule

// File: rtl/csf_core.sv
// status flag register with instruction flag effects, flow control and interrupt entry
`timescale 1ns/1ps
module csf_core
    import csf_pkg::*;
#(
    parameter int PC_W = 10
)
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic op_valid,
    input wire csf_op_t op_code,
    input wire logic [7:0] op_a,
    input wire logic [7:0] op_a_hi,
    input wire logic [7:0] op_b,
    input wire logic [2:0] op_bit,
    input wire logic [11:0] op_offset,
    input wire logic [PC_W-1:0] op_addr,
    input wire logic op_next_two_word,
    input wire logic [15:0] z_ptr,
    input wire logic [PC_W-1:0] stack_pc,
    input wire logic [PC_W-1:0] irq_vector,
    input wire logic [7:0] general_irq_mask,
    input wire logic [7:0] general_irq_flags,
    input wire logic [7:0] timer_irq_mask,
    input wire logic [7:0] timer_irq_flags,
    input wire logic [5:0] io_addr,
    input wire logic io_we,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic op_ready,
    output logic [PC_W-1:0] pc,
    output logic [15:0] result,
    output logic result_we,
    output logic [7:0] cpu_status_flags,
    output logic irq_take,
    output logic push_we,
    output logic [PC_W-1:0] push_pc,
    output logic pop_re
);
    logic accept;
    logic irq_go;
    logic irq_any;
    logic [2:0] cyc_left;
    logic busy;
    logic [15:0] unit_res;
    logic [7:0] unit_flags;
    logic unit_wb;
    logic [7:0] next_flags;
    logic [PC_W-1:0] off_ext;
    logic [PC_W-1:0] pc_rel;
    logic [PC_W-1:0] pc_inc;
    logic [PC_W-1:0] pc_skip;
    logic skip_cond;
    logic branch_cond;
    logic [2:0] op_cycles;
    logic [PC_W-1:0] next_pc;
    logic bst_bit;

    csf_flag_unit u_flag_unit (
        .op(op_code),
        .a(op_a),
        .a_hi(op_a_hi),
        .b(op_b),
        .bit_sel(op_bit),
        .flags_in(cpu_status_flags),
        .res(unit_res),
        .flags_out(unit_flags),
        .wb(unit_wb)
    );

    // masks only count while global enable set
    assign irq_any = |(general_irq_mask & general_irq_flags) |
                     |(timer_irq_mask & timer_irq_flags);
    assign busy = (cyc_left != 3'h0);
    assign irq_go = !busy && cpu_status_flags[CSF_BIT_I] && irq_any;
    assign op_ready = !busy && !irq_go;
    assign accept = op_valid && op_ready;

    assign off_ext = PC_W'({{16{op_offset[11]}}, op_offset});
    assign pc_inc = pc + PC_W'(1);
    // relative target pc plus offset plus one
    assign pc_rel = pc + off_ext + PC_W'(1);
    assign pc_skip = op_next_two_word ? (pc + PC_W'(3)) : (pc + PC_W'(2));
    assign bst_bit = op_a[op_bit];

    // skip conditions
    always_comb begin
        case (op_code)
            CSF_CPSE: skip_cond = (op_a == op_b);
            CSF_SBRC, CSF_SBIC: skip_cond = !op_a[op_bit];
            CSF_SBRS, CSF_SBIS: skip_cond = op_a[op_bit];
            default: skip_cond = 1'b0;
        endcase
    end

    // one flag tested, set and clear forms
    always_comb begin
        case (op_code)
            CSF_BRBS: branch_cond = cpu_status_flags[op_bit];
            CSF_BRBC: branch_cond = !cpu_status_flags[op_bit];
            default: branch_cond = 1'b0;
        endcase
    end

    // cycle cost and next pc per operation
    always_comb begin
        op_cycles = CSF_CYC_ONE;
        next_pc = pc_inc;
        case (op_code)
            // relative jump in one cycle
            CSF_RJMP: next_pc = pc_rel;
            // indirect and direct jumps in two
            CSF_IJMP: begin
                next_pc = z_ptr[PC_W-1:0];
                op_cycles = CSF_CYC_JUMP;
            end
            CSF_JMP: begin
                next_pc = op_addr;
                op_cycles = CSF_CYC_JUMP;
            end
            // calls take three cycles
            CSF_RCALL: begin
                next_pc = pc_rel;
                op_cycles = CSF_CYC_CALL;
            end
            CSF_ICALL: begin
                next_pc = z_ptr[PC_W-1:0];
                op_cycles = CSF_CYC_CALL;
            end
            CSF_CALL: begin
                next_pc = op_addr;
                op_cycles = CSF_CYC_CALL;
            end
            // returns reload from stack in four
            CSF_RET, CSF_IRQ_RET: begin
                next_pc = stack_pc;
                op_cycles = CSF_CYC_RET;
            end
            // skip over one or two words
            CSF_CPSE, CSF_SBRC, CSF_SBRS, CSF_SBIC, CSF_SBIS: begin
                if (skip_cond) begin
                    next_pc = pc_skip;
                    op_cycles = op_next_two_word ? CSF_CYC_SKIP_TWO : CSF_CYC_SKIP_ONE;
                end
            end
            // taken branch costs one extra cycle
            CSF_BRBS, CSF_BRBC: begin
                if (branch_cond) begin
                    next_pc = pc_rel;
                    op_cycles = CSF_CYC_BRANCH;
                end
            end
            default: begin
                next_pc = pc_inc;
                op_cycles = CSF_CYC_ONE;
            end
        endcase
    end

    // occupancy counter, stalls new operations
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_left <= 3'h0;
        end else if (irq_go) begin
            cyc_left <= CSF_CYC_IRQ - 3'h1;
        end else if (accept) begin
            cyc_left <= op_cycles - 3'h1;
        end else if (busy) begin
            cyc_left <= cyc_left - 3'h1;
        end
    end

    // program counter
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc <= '0;
        end else if (irq_go) begin
            pc <= irq_vector;
        end else if (accept) begin
            pc <= next_pc;
        end
    end

    // stack push and pop strobes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            push_we <= 1'b0;
            push_pc <= '0;
            pop_re <= 1'b0;
        end else begin
            push_we <= irq_go || (accept && ((op_code == CSF_RCALL) ||
                       (op_code == CSF_ICALL) || (op_code == CSF_CALL)));
            push_pc <= irq_go ? pc : pc_inc;
            pop_re <= accept && ((op_code == CSF_RET) || (op_code == CSF_IRQ_RET));
        end
    end

    // register result write-back
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= 16'h0000;
            result_we <= 1'b0;
        end else begin
            result_we <= accept && unit_wb;
            if (accept && unit_wb) begin
                result <= unit_res;
            end
        end
    end

    // software write first; instruction flags override all its bits but enable, which only interrupt entry and return override
    always_comb begin
        next_flags = cpu_status_flags;
        // all bits but sign writable at its address
        if (io_we && (io_addr == CSF_STATUS_ADDR)) begin
            next_flags = io_wdata;
        end
        if (accept) begin
            next_flags = unit_flags;
            if (io_we && (io_addr == CSF_STATUS_ADDR)) begin
                next_flags[CSF_BIT_I] = io_wdata[CSF_BIT_I];
            end
            // interrupt return sets global enable
            if (op_code == CSF_IRQ_RET) begin
                next_flags[CSF_BIT_I] = 1'b1;
            end
        end
        // taking an interrupt clears global enable
        if (irq_go) begin
            next_flags[CSF_BIT_I] = 1'b0;
        end
        // sign tied to negative and overflow
        next_flags[CSF_BIT_S] = next_flags[CSF_BIT_N] ^ next_flags[CSF_BIT_V];
    end

    // status register, zero after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_status_flags <= CSF_STATUS_RESET;
        end else begin
            cpu_status_flags <= next_flags;
        end
    end

    // interrupt entry pulse
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_take <= 1'b0;
        end else begin
            irq_take <= irq_go;
        end
    end

    // read port, registered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata <= 8'h00;
        end else begin
            io_rdata <= (io_addr == CSF_STATUS_ADDR) ? cpu_status_flags : 8'h00;
        end
    end

    // interrupt only with enable set
    AST_IRQ_NEEDS_ENABLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        irq_take |-> $past(cpu_status_flags[CSF_BIT_I]) && $past(irq_any))
        else $error("interrupt taken with global enable clear");

    // enable cleared on interrupt entry
    AST_IRQ_CLEARS_ENABLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        irq_take |-> !cpu_status_flags[CSF_BIT_I] && (pc == $past(irq_vector)))
        else $error("interrupt entry did not clear enable or load vector");

    // interrupt return four cycles, enable set
    AST_IRET_FOUR: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_IRQ_RET)) |=>
            cpu_status_flags[CSF_BIT_I] && (pc == $past(stack_pc)) ##0 busy[*3] ##1 !busy)
        else $error("interrupt return wrong length or flags");

    // sign consistent
    AST_SIGN_XOR: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        cpu_status_flags[CSF_BIT_S] ==
            (cpu_status_flags[CSF_BIT_N] ^ cpu_status_flags[CSF_BIT_V]))
        else $error("sign flag not negative xor overflow");

    // bit store copies selected bit
    AST_BIT_STORE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_TBIT_STORE)) |=>
            cpu_status_flags[CSF_BIT_T] == $past(bst_bit))
        else $error("bit-copy flag does not hold stored bit");

    // zero flag after add
    AST_ADD_ZERO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_ADD)) |=>
            result_we && (cpu_status_flags[CSF_BIT_Z] == (result[7:0] == 8'h00)))
        else $error("zero flag disagrees with add result");

    // logic group keeps carry and half carry
    AST_LOGIC_KEEPS_C: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && !io_we && (op_code inside {CSF_AND, CSF_OR, CSF_EOR})) |=>
            $stable(cpu_status_flags[CSF_BIT_C]) && $stable(cpu_status_flags[CSF_BIT_H]))
        else $error("logic operation changed carry or half carry");

    // compares never write back, one cycle
    AST_COMPARE_NO_WB: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code inside {CSF_CP, CSF_CPC})) |=> !result_we && !busy)
        else $error("compare wrote a register or stalled");

    // relative jump one cycle, direct two
    AST_JUMP_CYCLES: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_JMP)) |=> (pc == $past(op_addr)) && busy ##1 !busy)
        else $error("direct jump wrong target or length");

    AST_RJMP_CYCLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_RJMP)) |=> (pc == $past(pc_rel)) && !busy)
        else $error("relative jump wrong target or length");

    // calls three cycles and push return
    AST_CALL_THREE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_CALL)) |=>
            push_we && (push_pc == $past(pc_inc)) ##0 busy[*2] ##1 !busy)
        else $error("call wrong length or return address");

    // skip over one word, two cycles
    AST_SKIP_EQUAL: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_CPSE) && (op_a == op_b) && !op_next_two_word) |=>
            (pc == $past(pc_skip)) && busy ##1 !busy)
        else $error("skip did not advance by two in two cycles");

    // signed greater-or-equal branch
    AST_SIGNED_GE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_BRBC) && (op_bit == 3'h4) &&
            !(cpu_status_flags[CSF_BIT_N] ^ cpu_status_flags[CSF_BIT_V])) |=>
            (pc == $past(pc_rel)) && busy)
        else $error("signed branch not taken when expected");

    // unsigned lower branch on carry
    AST_UNSIGNED_LO: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (accept && (op_code == CSF_BRBS) && (op_bit == 3'h0)) |=>
            (pc == ($past(cpu_status_flags[CSF_BIT_C]) ? $past(pc_rel) : $past(pc_inc))))
        else $error("carry branch target wrong");

endmodule

// File: bench/tb_cpu_status_flags_and_branching.sv
// self-checking bench for the status flag and flow core
`timescale 1ns/1ps
module tb_cpu_status_flags_and_branching
    import csf_pkg::*;
;
    typedef struct packed {csf_op_t op; logic [7:0] fi, a, ahi, b; logic [2:0] bt;
        logic [15:0] res; logic [7:0] fl;} csf_alu_row_t;
    typedef struct packed {csf_op_t op; logic [7:0] a; logic [2:0] bt; logic [11:0] off;
        logic ntw; logic [9:0] pc; logic [2:0] cyc;} csf_flow_row_t;
    logic core_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, op_next_two_word = 1'b0;
    logic io_we = 1'b0, op_ready, result_we, irq_take, push_we, pop_re;
    csf_op_t op_code = CSF_NOP;
    logic [7:0] op_a = 8'h00, op_a_hi = 8'h00, op_b = 8'h00, io_wdata = 8'h00;
    logic [7:0] general_irq_mask = 8'h00, general_irq_flags = 8'h00, io_rdata;
    logic [7:0] timer_irq_mask = 8'h00, timer_irq_flags = 8'h00, cpu_status_flags;
    logic [2:0] op_bit = 3'h0;
    logic [11:0] op_offset = 12'h000;
    logic [9:0] op_addr = 10'h100, stack_pc = 10'h201, irq_vector = 10'h3c0, pc, push_pc;
    logic [15:0] z_ptr = 16'h0200, result;
    logic [5:0] io_addr = 6'h3f;
    int n_fail = 0, total_checks = 0;
    csf_alu_row_t alu [18] = '{
        '{CSF_ADD, 8'h00, 8'h7f, 8'h00, 8'h01, 3'h0, 16'h0080, 8'h2c},
        '{CSF_ADC, 8'h01, 8'hff, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h23},
        '{CSF_SUB, 8'h00, 8'h00, 8'h00, 8'h01, 3'h0, 16'h00ff, 8'h35},
        '{CSF_SBC, 8'h01, 8'h80, 8'h00, 8'h00, 3'h0, 16'h007f, 8'h38},
        '{CSF_CP, 8'h00, 8'h05, 8'h00, 8'h05, 3'h0, 16'h0000, 8'h02},
        '{CSF_CPC, 8'h01, 8'h00, 8'h00, 8'h00, 3'h0, 16'h0000, 8'h35},
        '{CSF_OR, 8'h00, 8'h80, 8'h00, 8'h01, 3'h0, 16'h0081, 8'h14},
        '{CSF_AND, 8'h3f, 8'hf0, 8'h00, 8'h0f, 3'h0, 16'h0000, 8'h23},
        '{CSF_EOR, 8'h01, 8'h55, 8'h00, 8'h55, 3'h0, 16'h0000, 8'h03},
        '{CSF_INC, 8'h21, 8'h7f, 8'h00, 8'h00, 3'h0, 16'h0080, 8'h2d},
        '{CSF_DEC, 8'h00, 8'h80, 8'h00, 8'h00, 3'h0, 16'h007f, 8'h18},
        '{CSF_COM, 8'h00, 8'h00, 8'h00, 8'h00, 3'h0, 16'h00ff, 8'h15},
        '{CSF_NEG, 8'h00, 8'h01, 8'h00, 8'h00, 3'h0, 16'h00ff, 8'h35},
        '{CSF_SER, 8'h3f, 8'h12, 8'h00, 8'h00, 3'h0, 16'h00ff, 8'h2f},
        '{CSF_ADIW, 8'h00, 8'hff, 8'hff, 8'h01, 3'h0, 16'h0000, 8'h03},
        '{CSF_SBIW, 8'h00, 8'h00, 8'h80, 8'h01, 3'h0, 16'h7fff, 8'h18},
        '{CSF_TBIT_STORE, 8'h00, 8'h04, 8'h00, 8'h00, 3'h2, 16'h0000, 8'h40},
        '{CSF_TBIT_LOAD, 8'h40, 8'h00, 8'h00, 8'h00, 3'h5, 16'h0020, 8'h40}};
    csf_flow_row_t flw [16] = '{
        '{CSF_JMP, 8'h00, 3'h0, 12'h000, 1'b0, 10'h100, 3'h2},
        '{CSF_RJMP, 8'h00, 3'h0, 12'hffe, 1'b0, 10'h0ff, 3'h1},
        '{CSF_IJMP, 8'h00, 3'h0, 12'h000, 1'b0, 10'h200, 3'h2},
        '{CSF_RCALL, 8'h00, 3'h0, 12'h010, 1'b0, 10'h211, 3'h3},
        '{CSF_RET, 8'h00, 3'h0, 12'h000, 1'b0, 10'h201, 3'h4},
        '{CSF_CALL, 8'h00, 3'h0, 12'h000, 1'b0, 10'h100, 3'h3},
        '{CSF_ICALL, 8'h00, 3'h0, 12'h000, 1'b0, 10'h200, 3'h3},
        '{CSF_CPSE, 8'h5a, 3'h0, 12'h000, 1'b0, 10'h202, 3'h2},
        '{CSF_SBRS, 8'h01, 3'h0, 12'h000, 1'b1, 10'h205, 3'h3},
        '{CSF_SBIC, 8'h01, 3'h0, 12'h000, 1'b0, 10'h206, 3'h1},
        '{CSF_BRBC, 8'h00, 3'h4, 12'h004, 1'b0, 10'h20b, 3'h2},
        '{CSF_BRBS, 8'h00, 3'h4, 12'h004, 1'b0, 10'h20c, 3'h1},
        '{CSF_BRBS, 8'h00, 3'h0, 12'hffe, 1'b0, 10'h20b, 3'h2},
        '{CSF_BRBC, 8'h00, 3'h0, 12'h004, 1'b0, 10'h20c, 3'h1},
        '{CSF_SBRC, 8'h01, 3'h1, 12'h000, 1'b0, 10'h20e, 3'h2},
        '{CSF_SBIS, 8'h01, 3'h0, 12'h000, 1'b1, 10'h211, 3'h3}};
    csf_core uut (.core_clk, .rst_n, .op_valid, .op_code, .op_a, .op_a_hi, .op_b, .op_bit,
        .op_offset, .op_addr, .op_next_two_word, .z_ptr, .stack_pc, .irq_vector,
        .general_irq_mask, .general_irq_flags, .timer_irq_mask, .timer_irq_flags, .io_addr,
        .io_we, .io_wdata, .io_rdata, .op_ready, .pc, .result, .result_we, .cpu_status_flags,
        .irq_take, .push_we, .push_pc, .pop_re);
    always #2.5 core_clk = ~core_clk;
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wait_for(input int kind);
        int i;
        i = 0;
        while ((kind ? irq_take : op_ready) !== 1'b1 && i < 20) begin
            tick;
            i++;
        end
        if (i == 20) begin
            n_fail++;
            stop_test;
        end
    endtask
    task automatic wr_status(input logic [7:0] v);
        io_wdata = v;
        io_we = 1'b1;
        tick;
        io_we = 1'b0;
    endtask
    task automatic go;
        tick;
        wait_for(0);
        op_valid = 1'b1;
        tick;
        op_valid = 1'b0;
    endtask
    task automatic cyc_chk(input int exp);
        int n;
        n = 1;
        while (op_ready !== 1'b1 && n < 10) begin
            tick;
            n++;
        end
        chk("cycles", exp, n);
    endtask
    initial begin
        logic wb;
        logic [9:0] prev;
        repeat (6) tick;
        rst_n = 1'b1;
        chk("reset flags", 8'h00, cpu_status_flags);
        wr_status(8'hff);
        chk("status write", 8'hef, cpu_status_flags);
        tick;
        chk("status read", 8'hef, io_rdata);
        io_addr = 6'h3e;
        repeat (2) tick;
        chk("unmapped read", 8'h00, io_rdata);
        io_addr = 6'h3f;
        $display("status test done");
        foreach (alu[i]) begin
            wr_status(alu[i].fi);
            op_code = alu[i].op;
            op_a = alu[i].a;
            op_a_hi = alu[i].ahi;
            op_b = alu[i].b;
            op_bit = alu[i].bt;
            go;
            wb = !(alu[i].op inside {CSF_CP, CSF_CPC, CSF_TBIT_STORE});
            chk("flags", alu[i].fl, cpu_status_flags);
            chk("write", wb, result_we);
            if (wb) chk("result", alu[i].res, result & (alu[i].ahi ? 16'hffff : 16'h00ff));
            cyc_chk(1);
            $display("alu row %0d done", i);
        end
        wr_status(8'h0d);
        op_b = 8'h5a;
        prev = 10'h000;
        foreach (flw[i]) begin
            op_code = flw[i].op;
            op_a = flw[i].a;
            op_bit = flw[i].bt;
            op_offset = flw[i].off;
            op_next_two_word = flw[i].ntw;
            go;
            chk("pc", flw[i].pc, pc);
            chk("flags kept", 8'h0d, cpu_status_flags);
            if (flw[i].op inside {CSF_RCALL, CSF_CALL, CSF_ICALL})
                chk("push", {1'b1, prev + 10'h001}, {push_we, push_pc});
            if (flw[i].op == CSF_RET) chk("pop", 1'b1, pop_re);
            cyc_chk(flw[i].cyc);
            prev = flw[i].pc;
            $display("flow row %0d done", i);
        end
        general_irq_mask = 8'hff;
        general_irq_flags = 8'h01;
        repeat (3) tick;
        chk("gated irq", 2'b01, {irq_take, op_ready});
        wr_status(8'h80);
        wait_for(1);
        chk("irq entry", {1'b1, irq_vector}, {push_we, pc});
        chk("irq clears enable", 8'h00, cpu_status_flags);
        general_irq_mask = 8'h00;
        op_code = CSF_IRQ_RET;
        go;
        chk("return pc", {1'b1, stack_pc}, {pop_re, pc});
        chk("return enable", 8'h80, cpu_status_flags);
        cyc_chk(4);
        timer_irq_mask = 8'h04;
        timer_irq_flags = 8'h04;
        wait_for(1);
        chk("timer irq", irq_vector, pc);
        timer_irq_flags = 8'h00;
        $display("interrupt test done");
        wr_status(8'h7f);
        rst_n = 1'b0;
        #1;
        chk("async reset", 8'h00, cpu_status_flags);
        $display("reset test done");
        stop_test;
    end
endmodule
